//--- mpc_pkg.sv
// Constants, field layout and types for the MAC management and pause control block.
// Behaviour
// - Bits 15 to 11 of the management address register pick one of 32 PHY addresses.
// - Bits 10 to 6 of the management address register pick the register inside that PHY.
// - Bit 1 of the management address register written as one runs a write, as zero a read.
// - The management busy flag at bit 0 stays high while an instruction runs and then clears.
// - Bits 15 to 0 of the data register hold the word to write or the word read back.
// - Bits 31 to 16 of the flow control register go into every transmitted pause frame.
// - With bit 1 of the flow control register set, received pause frames hold off the sender.
// - Setting the pause busy bit starts a pause frame and the bit stays high while it is sent.
// - The pause busy bit clears by itself once the pause frame has gone out.
// - Each transmitted frame longer than bits 13 to 3 of counter control counts as long.
`default_nettype none
package mpc_pkg;
  // Register addresses on the indirect register port.
  localparam logic [15:0] ADDR_MGMT_CMD = 16'h0014;
  localparam logic [15:0] ADDR_MGMT_DATA = 16'h0018;
  localparam logic [15:0] ADDR_FLOW = 16'h001C;
  localparam logic [15:0] ADDR_CNT_CTRL = 16'h0100;
  localparam logic [15:0] ADDR_LONG_CNT = 16'h0104;
  // Field positions.
  localparam int PHY_LSB = 11;
  localparam int REG_LSB = 6;
  localparam int DIR_BIT = 1;
  localparam int BUSY_BIT = 0;
  localparam int PAU_LSB = 16;
  localparam int APE_BIT = 1;
  localparam int PSB_BIT = 0;
  localparam int MFL_LSB = 3;
  localparam int CC_RSV_BIT = 1;
  // Values after reset.
  localparam logic [4:0] PHY_RST = 5'h0B;
  localparam logic [4:0] REG_RST = 5'h0B;
  localparam logic [15:0] PAU_RST = 16'h0050;
  localparam logic APE_RST = 1'b1;
  localparam logic [10:0] MFL_RST = 11'h5EE;
  localparam logic CC_RSV_RST = 1'b1;
  // Management clock: shortest period in ns.
  localparam int CLK_PERIOD_NS = 25;
  localparam int MDC_PERIOD_NS = 400;
  localparam int MDC_HALF_CYC = (MDC_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
  localparam int PHASE_W = $clog2(2 * MDC_HALF_CYC);
  // Management frame layout in bits.
  localparam int FRAME_BITS = 64;
  localparam int READ_DRIVE_BITS = 46;
  localparam int DATA_FIRST_BIT = 48;
  // One slot time is 512 bit times, four bits per link clock.
  localparam int SLOT_BITS = 512;
  localparam int BITS_PER_LINK_CYC = 4;
  localparam int SLOT_CYC = SLOT_BITS / BITS_PER_LINK_CYC;
  typedef enum logic {MD_IDLE, MD_SHIFT} mpc_md_state_type;
  // True when a write strobe hits the given register address.
  function automatic logic mpc_hit(input logic wr, input logic [15:0] a, input logic [15:0] t);
    return wr && (a == t);
  endfunction
endpackage
`default_nettype wire

//--- mpc_if.sv
// Interfaces between the register side, the management engine and the link side.
`timescale 1ns/10ps
`default_nettype none
interface mpc_mdio_if;
  logic        start;
  logic        wr;
  logic [4:0]  phy;
  logic [4:0]  regad;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        done;
  modport ctl (output start, wr, phy, regad, wdata, input rdata, done);
  modport eng (input start, wr, phy, regad, wdata, output rdata, done);
endinterface
interface mpc_link_if;
  logic        pause_tog;
  logic [15:0] pause_time;
  logic        fce;
  logic        mfl_tog;
  logic [10:0] mfl;
  logic        done_tog;
  logic        mfl_ack_tog;
  logic        lf_tog;
  modport host (output pause_tog, pause_time, fce, mfl_tog, mfl,
                input done_tog, mfl_ack_tog, lf_tog);
  modport link (input pause_tog, pause_time, fce, mfl_tog, mfl,
                output done_tog, mfl_ack_tog, lf_tog);
endinterface
`default_nettype wire

//--- mpc_mdio.sv
// Management bus engine: builds one clause 22 frame and shifts it on the management pins.
`timescale 1ns/10ps
`default_nettype none
module mpc_mdio (
  input  wire logic clk_i,
  input  wire logic resetn_i,
  mpc_mdio_if.eng   md,
  input  wire logic mdio_i,
  output logic      mdc_o,
  output logic      mdio_o,
  output logic      mdio_oe_o
);
  localparam logic [mpc_pkg::PHASE_W-1:0] PH_LAST =
    (mpc_pkg::PHASE_W)'(2 * mpc_pkg::MDC_HALF_CYC - 1);
  localparam logic [mpc_pkg::PHASE_W-1:0] PH_RISE = (mpc_pkg::PHASE_W)'(mpc_pkg::MDC_HALF_CYC);
  mpc_pkg::mpc_md_state_type     state_reg;
  logic [mpc_pkg::PHASE_W-1:0]   phase_reg;
  logic [5:0]                    bit_reg;
  logic [63:0]                   frame_reg;
  logic                          wr_reg;
  logic                          sync1_reg;
  logic                          sync2_reg;
  // Pin input passes two flops before the shifter looks at it.
  always_ff @(posedge clk_i) begin
    sync1_reg <= mdio_i;
    sync2_reg <= sync1_reg;
  end
  // Frame sequencer; dividing the clock here avoids a second domain.
  always_ff @(posedge clk_i) begin
    md.done <= 1'b0;
    if (!resetn_i) begin
      state_reg <= mpc_pkg::MD_IDLE;
      phase_reg <= '0;
      bit_reg <= 6'h00;
      frame_reg <= 64'h0;
      wr_reg <= 1'b0;
      mdc_o <= 1'b0;
      mdio_o <= 1'b0;
      mdio_oe_o <= 1'b0;
      md.rdata <= 16'h0000;
    end else begin
      unique case (state_reg)
        mpc_pkg::MD_IDLE: begin
          mdc_o <= 1'b0;
          mdio_oe_o <= 1'b0;
          if (md.start) begin
            // Preamble, start, opcode, addresses, turnaround, data.
            frame_reg <= {32'hFFFF_FFFF, 2'b01, md.wr ? 2'b01 : 2'b10,
                          md.phy, md.regad,
                          md.wr ? 2'b10 : 2'b00, md.wr ? md.wdata : 16'h0000};
            wr_reg <= md.wr;
            bit_reg <= 6'h00;
            phase_reg <= '0;
            state_reg <= mpc_pkg::MD_SHIFT;
          end
        end
        mpc_pkg::MD_SHIFT: begin
          phase_reg <= (phase_reg == PH_LAST) ? '0 : phase_reg + 1'b1;
          mdc_o <= (phase_reg + 1'b1 >= PH_RISE) && (phase_reg != PH_LAST);
          if (phase_reg == '0) begin
            // Read frames release the pin from the turnaround onward.
            mdio_o <= frame_reg[63];
            mdio_oe_o <= wr_reg || (bit_reg < 6'(mpc_pkg::READ_DRIVE_BITS));
            frame_reg <= {frame_reg[62:0], 1'b0};
          end
          // Sample just before the rising edge, long after the PHY drove the bit.
          if (phase_reg == PH_RISE - 1'b1 && !wr_reg &&
              bit_reg >= 6'(mpc_pkg::DATA_FIRST_BIT)) begin
            md.rdata <= {md.rdata[14:0], sync2_reg};
          end
          if (phase_reg == PH_LAST) begin
            bit_reg <= bit_reg + 6'h01;
            if (bit_reg == 6'(mpc_pkg::FRAME_BITS - 1)) begin
              state_reg <= mpc_pkg::MD_IDLE;
              mdio_oe_o <= 1'b0;
              md.done <= 1'b1;
            end
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

//--- mpc_link.sv
// Link clock side: pause frame request, received pause hold-off and long frame check.
`timescale 1ns/10ps
`default_nettype none
module mpc_link (
  input  wire logic        tx_clk_i,
  input  wire logic        resetn_i,
  mpc_link_if.link         lk,
  input  wire logic        rx_pause_valid_i,
  input  wire logic [15:0] rx_pause_quanta_i,
  input  wire logic        tx_pause_sent_i,
  input  wire logic        tx_frame_end_i,
  input  wire logic [13:0] tx_frame_len_i,
  output logic             tx_pause_req_o,
  output logic [15:0]      tx_pause_time_o,
  output logic             tx_hold_o
);
  logic [1:0]  rst_sync_reg;
  logic [2:0]  pause_sync_reg;
  logic [2:0]  mfl_sync_reg;
  logic [1:0]  fce_sync_reg;
  logic [10:0] mfl_reg;
  logic [15:0] quanta_reg;
  logic [6:0]  slot_reg;
  logic        lrst_n;
  assign lrst_n = rst_sync_reg[1];
  // Reset, toggles and the enable level all cross by flop chains.
  always_ff @(posedge tx_clk_i) begin
    rst_sync_reg <= {rst_sync_reg[0], resetn_i};
    pause_sync_reg <= {pause_sync_reg[1:0], lk.pause_tog};
    mfl_sync_reg <= {mfl_sync_reg[1:0], lk.mfl_tog};
    fce_sync_reg <= {fce_sync_reg[0], lk.fce};
  end
  // Pause frame request held until the transmitter reports it sent.
  always_ff @(posedge tx_clk_i) begin
    if (!lrst_n) begin
      tx_pause_req_o <= 1'b0;
      tx_pause_time_o <= 16'h0000;
      lk.done_tog <= 1'b0;
    end else if (pause_sync_reg[2] != pause_sync_reg[1]) begin
      tx_pause_req_o <= 1'b1;
      tx_pause_time_o <= lk.pause_time;
    end else if (tx_pause_req_o && tx_pause_sent_i) begin
      tx_pause_req_o <= 1'b0;
      lk.done_tog <= ~lk.done_tog;
    end
  end
  // Hold-off timer in slot times; a new pause frame restarts it, zero quanta ends it.
  always_ff @(posedge tx_clk_i) begin
    if (!lrst_n) begin
      tx_hold_o <= 1'b0;
      quanta_reg <= 16'h0000;
      slot_reg <= 7'h00;
    end else if (fce_sync_reg[1] && rx_pause_valid_i) begin
      quanta_reg <= rx_pause_quanta_i;
      slot_reg <= 7'h00;
      tx_hold_o <= (rx_pause_quanta_i != 16'h0000);
    end else if (tx_hold_o) begin
      slot_reg <= slot_reg + 7'h01;
      if (slot_reg == 7'(mpc_pkg::SLOT_CYC - 1)) begin
        quanta_reg <= quanta_reg - 16'h0001;
        tx_hold_o <= (quanta_reg != 16'h0001);
      end
    end
  end
  // Limit handshake and long frame events back to the register side.
  always_ff @(posedge tx_clk_i) begin
    if (!lrst_n) begin
      mfl_reg <= mpc_pkg::MFL_RST;
      lk.mfl_ack_tog <= 1'b0;
      lk.lf_tog <= 1'b0;
    end else begin
      if (mfl_sync_reg[2] != mfl_sync_reg[1]) begin
        mfl_reg <= lk.mfl;
        lk.mfl_ack_tog <= ~lk.mfl_ack_tog;
      end
      if (tx_frame_end_i && tx_frame_len_i > {3'b000, mfl_reg}) begin
        lk.lf_tog <= ~lk.lf_tog;
      end
    end
  end
endmodule
`default_nettype wire

//--- mpc_top.sv
// Management and pause control registers with the management engine and link side.
`timescale 1ns/10ps
`default_nettype none
module mpc_top (
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic [15:0] reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic [31:0]      reg_rdata_o,
  output logic             mdc_o,
  input  wire logic        mdio_i,
  output logic             mdio_o,
  output logic             mdio_oe_o,
  input  wire logic        tx_clk_i,
  input  wire logic        rx_pause_valid_i,
  input  wire logic [15:0] rx_pause_quanta_i,
  input  wire logic        tx_pause_sent_i,
  input  wire logic        tx_frame_end_i,
  input  wire logic [13:0] tx_frame_len_i,
  output logic             tx_pause_req_o,
  output logic [15:0]      tx_pause_time_o,
  output logic             tx_hold_o
);

  mpc_mdio_if md ();
  mpc_link_if lk ();

  // Management address and data register fields.
  logic [4:0]  phy_select_reg;
  logic [4:0]  phy_reg_select_reg;
  logic        mgmt_write_dir_reg;
  logic        mgmt_busy_flag_reg;
  logic [15:0] mgmt_data_word_reg;
  // Flow control register fields.
  logic [15:0] pause_time_value_reg;
  logic        auto_pause_enable_reg;
  logic        pause_send_busy_reg;
  // Counter control and long count.
  logic [10:0] max_frame_length_reg;
  logic        cc_rsv_reg;
  logic [31:0] long_cnt_reg;
  // Register side of the crossings.
  logic        start_reg;
  logic        pause_tog_reg;
  logic [15:0] pause_shadow_reg;
  logic        mfl_tog_reg;
  logic [10:0] mfl_shadow_reg;
  logic [2:0]  done_sync_reg;
  logic [2:0]  lf_sync_reg;
  logic [1:0]  ack_sync_reg;

  // Strobe decode.
  logic        wr_cmd, wr_data, wr_flow, wr_cc, pause_done, long_evt, mfl_idle;

  assign wr_cmd = mpc_pkg::mpc_hit(reg_wr_i, reg_addr_i, mpc_pkg::ADDR_MGMT_CMD);
  assign wr_data = mpc_pkg::mpc_hit(reg_wr_i, reg_addr_i, mpc_pkg::ADDR_MGMT_DATA);
  assign wr_flow = mpc_pkg::mpc_hit(reg_wr_i, reg_addr_i, mpc_pkg::ADDR_FLOW);
  assign wr_cc = mpc_pkg::mpc_hit(reg_wr_i, reg_addr_i, mpc_pkg::ADDR_CNT_CTRL);

  // Returned toggles: done and long frame edges are taken between the second and third flops.
  assign pause_done = done_sync_reg[2] != done_sync_reg[1];
  assign long_evt = lf_sync_reg[2] != lf_sync_reg[1];
  assign mfl_idle = ack_sync_reg[1] == mfl_tog_reg;

  // Link toggles pass two flops before any logic reads them.
  always_ff @(posedge clk_i) begin
    done_sync_reg <= {done_sync_reg[1:0], lk.done_tog};
    lf_sync_reg <= {lf_sync_reg[1:0], lk.lf_tog};
    ack_sync_reg <= {ack_sync_reg[0], lk.mfl_ack_tog};
  end

  // Command register; a write while busy is dropped so the running frame keeps its fields.
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      phy_select_reg <= mpc_pkg::PHY_RST;
      phy_reg_select_reg <= mpc_pkg::REG_RST;
      mgmt_write_dir_reg <= 1'b0;
      mgmt_busy_flag_reg <= 1'b0;
      start_reg <= 1'b0;
    end else begin
      start_reg <= 1'b0;
      if (wr_cmd && !mgmt_busy_flag_reg) begin
        phy_select_reg <= reg_wdata_i[mpc_pkg::PHY_LSB +: 5];
        phy_reg_select_reg <= reg_wdata_i[mpc_pkg::REG_LSB +: 5];
        mgmt_write_dir_reg <= reg_wdata_i[mpc_pkg::DIR_BIT];
        mgmt_busy_flag_reg <= 1'b1;
        start_reg <= 1'b1;
      end else if (md.done) begin
        mgmt_busy_flag_reg <= 1'b0;
      end
    end
  end

  // Request to the engine; address and direction fields are stable for the whole frame.
  assign md.start = start_reg;
  assign md.wr = mgmt_write_dir_reg;
  assign md.phy = phy_select_reg;
  assign md.regad = phy_reg_select_reg;
  assign md.wdata = mgmt_data_word_reg;

  // Data register: a finished read loads it on the edge that clears busy.
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      mgmt_data_word_reg <= 16'h0000;
    end else if (md.done && !mgmt_write_dir_reg) begin
      mgmt_data_word_reg <= md.rdata;
    end else if (wr_data) begin
      mgmt_data_word_reg <= reg_wdata_i[15:0];
    end
  end

  // Flow control: pause time and enable are plain read-write fields.
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      pause_time_value_reg <= mpc_pkg::PAU_RST;
      auto_pause_enable_reg <= mpc_pkg::APE_RST;
    end else if (wr_flow) begin
      pause_time_value_reg <= reg_wdata_i[mpc_pkg::PAU_LSB +: 16];
      auto_pause_enable_reg <= reg_wdata_i[mpc_pkg::APE_BIT];
    end
  end

  // Only a one written while idle starts a frame; the time is frozen in a shadow
  // so a later write cannot tear it on its way across.
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      pause_send_busy_reg <= 1'b0;
      pause_tog_reg <= 1'b0;
      pause_shadow_reg <= mpc_pkg::PAU_RST;
    end else if (wr_flow && reg_wdata_i[mpc_pkg::PSB_BIT] && !pause_send_busy_reg) begin
      pause_send_busy_reg <= 1'b1;
      pause_tog_reg <= ~pause_tog_reg;
      pause_shadow_reg <= reg_wdata_i[mpc_pkg::PAU_LSB +: 16];
    end else if (pause_done) begin
      pause_send_busy_reg <= 1'b0;
    end
  end

  // Counter control register.
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      max_frame_length_reg <= mpc_pkg::MFL_RST;
      cc_rsv_reg <= mpc_pkg::CC_RSV_RST;
    end else if (wr_cc) begin
      max_frame_length_reg <= reg_wdata_i[mpc_pkg::MFL_LSB +: 11];
      cc_rsv_reg <= reg_wdata_i[mpc_pkg::CC_RSV_BIT];
    end
  end

  // A new limit crosses only once the last was taken, so the word never tears.
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      mfl_tog_reg <= 1'b0;
      mfl_shadow_reg <= mpc_pkg::MFL_RST;
    end else if (mfl_idle && mfl_shadow_reg != max_frame_length_reg) begin
      mfl_shadow_reg <= max_frame_length_reg;
      mfl_tog_reg <= ~mfl_tog_reg;
    end
  end

  // Long frame counter; wraps, cleared only by reset.
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      long_cnt_reg <= 32'h0000_0000;
    end else if (long_evt) begin
      long_cnt_reg <= long_cnt_reg + 32'h0000_0001;
    end
  end

  // Link crossing signals.
  assign lk.pause_tog = pause_tog_reg;
  assign lk.pause_time = pause_shadow_reg;
  assign lk.fce = auto_pause_enable_reg;
  assign lk.mfl_tog = mfl_tog_reg;
  assign lk.mfl = mfl_shadow_reg;

  // Read data one cycle after the strobe; unmapped and reserved bits read zero, except counter control bit 1, which reads back cc_rsv_reg.
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        mpc_pkg::ADDR_MGMT_CMD: begin
          reg_rdata_o <= {16'h0000, phy_select_reg, phy_reg_select_reg, 4'h0,
                          mgmt_write_dir_reg, mgmt_busy_flag_reg};
        end
        mpc_pkg::ADDR_MGMT_DATA: begin
          reg_rdata_o <= {16'h0000, mgmt_data_word_reg};
        end
        mpc_pkg::ADDR_FLOW: begin
          reg_rdata_o <= {pause_time_value_reg, 14'h0000,
                          auto_pause_enable_reg, pause_send_busy_reg};
        end
        mpc_pkg::ADDR_CNT_CTRL: begin
          reg_rdata_o <= {18'h00000, max_frame_length_reg, 1'b0, cc_rsv_reg, 1'b0};
        end
        mpc_pkg::ADDR_LONG_CNT: begin
          reg_rdata_o <= long_cnt_reg;
        end
        default: begin
          reg_rdata_o <= 32'h0000_0000;
        end
      endcase
    end
  end

  // Management bus engine.
  mpc_mdio u_mdio (
    .clk_i     (clk_i),
    .resetn_i  (resetn_i),
    .md        (md.eng),
    .mdio_i    (mdio_i),
    .mdc_o     (mdc_o),
    .mdio_o    (mdio_o),
    .mdio_oe_o (mdio_oe_o)
  );

  // Link clock side.
  mpc_link u_link (
    .tx_clk_i          (tx_clk_i),
    .resetn_i          (resetn_i),
    .lk                (lk.link),
    .rx_pause_valid_i  (rx_pause_valid_i),
    .rx_pause_quanta_i (rx_pause_quanta_i),
    .tx_pause_sent_i   (tx_pause_sent_i),
    .tx_frame_end_i    (tx_frame_end_i),
    .tx_frame_len_i    (tx_frame_len_i),
    .tx_pause_req_o    (tx_pause_req_o),
    .tx_pause_time_o   (tx_pause_time_o),
    .tx_hold_o         (tx_hold_o)
  );

endmodule
`default_nettype wire

//--- mpc_checker.sv
// Port-level assertions for the management and pause control block.
`timescale 1ns/10ps
`default_nettype none
module mpc_checker (
  input wire logic        clk_i,
  input wire logic        resetn_i,
  input wire logic [15:0] reg_addr_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic        mdc_o,
  input wire logic        mdio_o,
  input wire logic        mdio_oe_o,
  input wire logic        tx_clk_i,
  input wire logic        rx_pause_valid_i,
  input wire logic        tx_pause_sent_i,
  input wire logic        tx_pause_req_o,
  input wire logic        tx_hold_o
);
  logic [4:0] quiet_reg;
  // A frame never leaves the bus quiet for more than eight cycles, so a long quiet run means idle.
  always_ff @(posedge clk_i) begin
    if (!resetn_i || mdc_o || mdio_oe_o) quiet_reg <= 5'h00;
    else if (quiet_reg != 5'h1F) quiet_reg <= quiet_reg + 5'h01;
  end
  sequence cmd_wr_s;
    reg_wr_i && reg_addr_i == 16'h0014 && quiet_reg > 5'h10;
  endsequence
  sequence preamble_s;
    mdio_o [*8];
  endsequence
  // Register side checks.
  cmd_start_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    cmd_wr_s |-> ##[1:4] mdio_oe_o) else $error("command write did not drive the bus");
  frame_lead_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $rose(mdio_oe_o) |-> ##2 preamble_s) else $error("frame does not open with ones");
  mdc_half_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $rose(mdc_o) |-> mdc_o [*8] ##1 !mdc_o) else $error("bus clock high phase is wrong");
  cmd_rsv_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    reg_rd_i && reg_addr_i == 16'h0014 |=> reg_rdata_o[31:16] == 16'h0000
    && reg_rdata_o[5:2] == 4'h0) else $error("command register reserved bits set");
  data_rsv_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    reg_rd_i && reg_addr_i == 16'h0018 |=> reg_rdata_o[31:16] == 16'h0000)
    else $error("data register upper half set");
  flow_rsv_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    reg_rd_i && reg_addr_i == 16'h001C |=> reg_rdata_o[15:2] == 14'h0000)
    else $error("flow register reserved bits set");
  cnt_rsv_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    reg_rd_i && reg_addr_i == 16'h0100 |=> reg_rdata_o[31:14] == 18'h00000
    && reg_rdata_o[2] == 1'b0 && reg_rdata_o[0] == 1'b0) else $error("counter control bits set");
  // Link side checks.
  req_hold_a: assert property (@(posedge tx_clk_i) disable iff (!resetn_i)
    tx_pause_req_o && !tx_pause_sent_i |=> tx_pause_req_o) else $error("pause request dropped");
  req_drop_a: assert property (@(posedge tx_clk_i) disable iff (!resetn_i)
    $fell(tx_pause_req_o) |-> $past(tx_pause_sent_i)) else $error("pause request fell unsent");
  hold_cause_a: assert property (@(posedge tx_clk_i) disable iff (!resetn_i)
    $rose(tx_hold_o) |-> $past(rx_pause_valid_i)) else $error("hold-off without pause frame");
endmodule
bind mpc_top mpc_checker i_mpc_checker (.clk_i(clk_i), .resetn_i(resetn_i),
  .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .mdc_o(mdc_o), .mdio_o(mdio_o), .mdio_oe_o(mdio_oe_o),
  .tx_clk_i(tx_clk_i), .rx_pause_valid_i(rx_pause_valid_i), .tx_pause_sent_i(tx_pause_sent_i),
  .tx_pause_req_o(tx_pause_req_o), .tx_hold_o(tx_hold_o));
`default_nettype wire

//--- mpc_phy_model.sv
// Behavioural management-bus PHY that stores written words and answers reads.
`timescale 1ns/10ps
`default_nettype none
module mpc_phy_model (
  input  wire logic   mdc_i,
  input  wire logic   mdio_i,
  output logic        mdio_o,
  output logic [9:0]  wr_addr_o,
  output logic [15:0] wr_data_o
);
  logic [15:0] mem [1024];
  logic [63:0] sr = 64'h0;
  logic [6:0]  n = 7'h00;
  logic [9:0]  a = 10'h000;
  logic        is_wr = 1'b1;
  // Each word starts as a pattern of its own address, so reads differ.
  initial begin
    for (int i = 0; i < 1024; i++) mem[i] = {6'h2A, 10'(i)};
    mdio_o = 1'b1;
    wr_addr_o = 10'h000;
    wr_data_o = 16'h0000;
  end
  // Decode after 32 ones and a start pair; drive read bits after each rising clock.
  always @(posedge mdc_i) begin
    sr = {sr[62:0], mdio_i};
    if (n == 7'h00) begin
      if (sr[33:0] === {32'hFFFFFFFF, 2'b01}) n = 7'h02;
    end else n = n + 7'h01;
    if (n == 7'h0E) begin
      is_wr = (sr[11:10] == 2'b01);
      a = sr[9:0];
    end
    if (n == 7'h20) begin
      if (is_wr) begin
        mem[a] = sr[15:0];
        wr_addr_o = a;
        wr_data_o = sr[15:0];
      end
      n = 7'h00;
    end
    // A released line floats high through its pull-up.
    mdio_o = (!is_wr && n >= 7'h0F) ? (n == 7'h0F ? 1'b0 : mem[a][31 - n]) : 1'b1;
  end
endmodule
`default_nettype wire

//--- mpc_top_tb_top.sv
// Self-checking bench for the management and pause control block.
`timescale 1ns/10ps
`default_nettype none
module mpc_top_tb_top;
  logic        clk_i = 1'b0, tx_clk_i = 1'b0, resetn_i = 1'b0;
  logic        reg_wr_i = 1'b0, reg_rd_i = 1'b0, mdc_o, mdio_o, mdio_oe_o, phy_out, mdio_line;
  logic [15:0] reg_addr_i = 16'h0000, rx_pause_quanta_i = 16'h0000, tx_pause_time_o, wr_data;
  logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, rd_v;
  logic        rx_pause_valid_i = 1'b0, tx_pause_sent_i = 1'b0, tx_frame_end_i = 1'b0;
  logic [13:0] tx_frame_len_i = 14'h0000;
  logic        tx_pause_req_o, tx_hold_o;
  logic [9:0]  wr_addr;
  int          err_total = 0, total_checks = 0;
  logic [15:0] ra [6] = '{16'h0014, 16'h0018, 16'h001C, 16'h0100, 16'h0104, 16'h0040};
  logic [31:0] rv [6] = '{32'h00005AC0, 32'h0, 32'h00500002, 32'h00002F72, 32'h0, 32'h0};
  logic [9:0]  rp [2] = '{10'h266, 10'h3FF};
  logic [15:0] re [2] = '{16'hA5C3, 16'hABFF};
  // Two unrelated clocks; the line is driven by whichever side has it.
  always #12.5 clk_i = ~clk_i;
  always #6 tx_clk_i = ~tx_clk_i;
  assign mdio_line = mdio_oe_o ? mdio_o : phy_out;
  mpc_top i_mpc_top (.clk_i(clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .mdc_o(mdc_o), .mdio_i(mdio_line), .mdio_o(mdio_o),
    .mdio_oe_o(mdio_oe_o), .tx_clk_i(tx_clk_i), .rx_pause_valid_i(rx_pause_valid_i),
    .rx_pause_quanta_i(rx_pause_quanta_i), .tx_pause_sent_i(tx_pause_sent_i),
    .tx_frame_end_i(tx_frame_end_i), .tx_frame_len_i(tx_frame_len_i),
    .tx_pause_req_o(tx_pause_req_o), .tx_pause_time_o(tx_pause_time_o), .tx_hold_o(tx_hold_o));
  mpc_phy_model i_mpc_phy_model (.mdc_i(mdc_o), .mdio_i(mdio_line), .mdio_o(phy_out),
    .wr_addr_o(wr_addr), .wr_data_o(wr_data));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  // Read data lands on the edge that takes the strobe and is picked up at the next falling edge.
  task automatic rd(input logic [15:0] a);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    @(negedge clk_i);
    rd_v = reg_rdata_o;
  endtask
  // Software polls busy before issuing anything new.
  task automatic wait_clear(input logic [15:0] a);
    int i = 0;
    rd(a);
    while (rd_v[0] !== 1'b0 && i < 1000) begin
      rd(a);
      i++;
    end
    chk("busy clear", 32'h0, {31'h0, rd_v[0]});
  endtask
  // One link pulse: 0 received pause, 1 pause sent, 2 frame end.
  task automatic lpulse(input int k, input logic [15:0] v);
    @(posedge tx_clk_i);
    rx_pause_valid_i <= (k == 0);
    tx_pause_sent_i <= (k == 1);
    tx_frame_end_i <= (k == 2);
    rx_pause_quanta_i <= v;
    tx_frame_len_i <= v[13:0];
    @(posedge tx_clk_i);
    {rx_pause_valid_i, tx_pause_sent_i, tx_frame_end_i} <= 3'b000;
  endtask
  task automatic hold_count(input logic [15:0] q, input logic [31:0] e);
    int c = 0;
    lpulse(0, q);
    repeat (400) begin
      #1;
      c += (tx_hold_o === 1'b1);
      @(posedge tx_clk_i);
    end
    chk("hold cycles", e, 32'(c));
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Watchdog at about four times the expected run.
  initial begin
    #400000;
    err_total++;
    test_done();
  end
  initial begin
    int i;
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    foreach (ra[k]) begin
      rd(ra[k]);
      chk("reset value", rv[k], rd_v);
    end
    // A write instruction, with a second command refused while busy.
    wr(16'h0018, 32'h0000A5C3);
    wr(16'h0014, 32'h00009982);
    wr(16'h0014, 32'h00000002);
    rd(16'h0014);
    chk("command busy", 32'h00009983, rd_v);
    wait_clear(16'h0014);
    chk("phy address", 32'h266, {22'h0, wr_addr});
    chk("phy data", 32'hA5C3, {16'h0, wr_data});
    // Reads, the highest PHY and register address included.
    for (int k = 0; k < 2; k++) begin
      wr(16'h0014, {16'h0, rp[k], 6'h00});
      wait_clear(16'h0014);
      rd(16'h0018);
      chk("read word", {16'h0, re[k]}, rd_v);
    end
    // Pause request, a second one while busy, then a zero write.
    wr(16'h001C, 32'h12340003);
    rd(16'h001C);
    chk("pause busy", 32'h12340003, rd_v);
    i = 0;
    while (tx_pause_req_o !== 1'b1 && i < 50) begin
      @(posedge tx_clk_i);
      i++;
    end
    chk("pause time", 32'h1234, {16'h0, tx_pause_time_o});
    wr(16'h001C, 32'h55550003);
    lpulse(1, 16'h0000);
    wait_clear(16'h001C);
    rd(16'h001C);
    chk("flow after", 32'h55550002, rd_v);
    wr(16'h001C, 32'h55550002);
    repeat (20) @(posedge tx_clk_i);
    chk("no new pause", 32'h0, {31'h0, tx_pause_req_o});
    // Received pause: enabled, zero quanta, then disabled.
    hold_count(16'h0002, 32'd256);
    hold_count(16'h0000, 32'd0);
    wr(16'h001C, 32'h00000000);
    repeat (10) @(posedge tx_clk_i);
    hold_count(16'h0002, 32'd0);
    // Frame lengths around a 100 byte limit.
    wr(16'h0100, 32'h00000322);
    rd(16'h0100);
    chk("count control", 32'h00000322, rd_v);
    repeat (10) @(posedge tx_clk_i);
    foreach (rp[k]) begin
      lpulse(2, k == 0 ? 16'd100 : 16'd101);
      repeat (6) @(posedge tx_clk_i);
    end
    lpulse(2, 16'h3FFF);
    repeat (10) @(posedge clk_i);
    rd(16'h0104);
    chk("long frames", 32'd2, rd_v);
    test_done();
  end
endmodule
`default_nettype wire
